// *** verilog/serial_port_pkg.sv ***
// shared constants and types for both ends of the converter serial link
package serial_port_pkg;
	localparam int          WORD_BITS    = 24;
	localparam int          SHORT_BITS   = 16;
	localparam int          SYS_CLK_MHZ  = 200;
	// half period of a serial clock made by either end
	localparam int          SCLK_HALF_NS = 80;
	localparam int          HALF_CYC     = (SCLK_HALF_NS * SYS_CLK_MHZ) / 1000;
	// host splits an external-clock frame after this many bits when asked to
	localparam int          SPLIT_AT     = 8;
	localparam logic [4:0]  LAST_LONG    = 5'h17;
	localparam logic [4:0]  LAST_SHORT   = 5'h0F;
	localparam logic [4:0]  SPLIT_BIT    = 5'h07;
	localparam logic [23:0] CTRL_RESET   = 24'h000000;
	localparam logic [23:0] WORD_RESET   = 24'h000000;
	typedef logic [WORD_BITS-1:0] word_t;
	typedef logic [4:0]           bit_cnt_t;
	typedef logic [7:0]           half_cnt_t;
	localparam half_cnt_t   HALF_LAST    = half_cnt_t'(HALF_CYC - 1);
endpackage : serial_port_pkg

// *** verilog/serial_link_if.sv ***
// serial link wires between converter port and host, with pin resolution
`timescale 1ns/1ps
interface serial_link_if;
	logic sclk_dev;
	logic sclk_dev_oe;
	logic sclk_host;
	logic sclk_host_oe;
	logic serial_data_line_dev;
	logic serial_data_line_dev_oe;
	logic serial_data_line_host;
	logic serial_data_line_host_oe;
	logic sclk;
	logic serial_data_line;
	logic read_frame_sync_n;
	logic transmit_frame_sync_n;
	logic register_select;
	logic data_ready_n;
	// undriven clock is pulled low, undriven data line pulled high
	assign sclk             = sclk_dev_oe ? sclk_dev : (sclk_host_oe ? sclk_host : 1'b0);
	assign serial_data_line = serial_data_line_dev_oe ? serial_data_line_dev : (serial_data_line_host_oe ? serial_data_line_host : 1'b1);
	modport device (
		input  sclk, serial_data_line, read_frame_sync_n, transmit_frame_sync_n, register_select,
		output sclk_dev, sclk_dev_oe, serial_data_line_dev, serial_data_line_dev_oe, data_ready_n
	);
	modport host (
		input  sclk, serial_data_line, data_ready_n,
		output sclk_host, sclk_host_oe, serial_data_line_host, serial_data_line_host_oe,
		output read_frame_sync_n, transmit_frame_sync_n, register_select
	);
endinterface : serial_link_if

// *** verilog/converter_serial_port.sv ***
// converter end of the serial link: shift logic on the link clock, registers on clk_sys_i
//
// Functional notes
// [R1] writes ignore and never touch ready flag
// [R2] host writes exactly 24 bits
// [R3] select picks control or calibration, held
// [R4] select low write loads control register
// [R5] self mode: write strobe starts own clock
// [R6] clock stops after falling edge past LSB
// [R7] mode low: clock pin is input
// [R8] mode high: device drives the clock (here for write frames only)
// [R9] read select high output/calib, low control
// [R10] ready low on new word, high after last
// [R11] unread word keeps updating, ready stays low
// [R12] word arriving mid-read is dropped silently
// [R13] control/calib reads ignore ready flag
// [R14] read strobe with ready high moves nothing
// [R15] host reads 24 bits from control/calib
// [R16] strobe shows MSB, falling edges shift
// [R17] final falling edge raises ready, data off
// [R18] host keeps clock low between transfers
// [R19] read strobe may pause; output tri-states
// [R20] ready stays low across split read
// [R21] write bits captured on clock high, MSB first
// [R22] split write resumes at next high level
// [R23] bit counter survives strobe pauses
`timescale 1ns/1ps
module converter_serial_port (
	// system clock and reset
	input  wire logic                      clk_sys_i,
	input  wire logic                      srst_i,
	// serial link
	serial_link_if.device                  link,
	// straps and configuration
	input  wire logic                      mode_self_i,
	input  wire logic                      calib_sel_i,
	// conversion results and calibration data
	input  wire serial_port_pkg::word_t    out_word_i,
	input  wire logic                      out_valid_i,
	input  wire logic                      out_len24_i,
	input  wire serial_port_pkg::word_t    calib_rd_i,
	// written registers
	output serial_port_pkg::word_t         ctrl_o,
	output logic                           ctrl_wr_o,
	output serial_port_pkg::word_t         calib_o,
	output logic                           calib_wr_o
);
	import serial_port_pkg::*;

	typedef struct packed {
		logic [1:0] mode_sync;
		logic [2:0] tfs_sync;
		logic [1:0] rfs_sync;
		logic [1:0] rs_sync;
		logic [2:0] wr_tgl_sync;
		logic [2:0] rd_tgl_sync;
		logic       data_ready_n_n;
		logic       busy;
		word_t      out_hold;
		logic       out_len24;
		word_t      ctrl;
		logic       ctrl_wr;
		word_t      calib;
		logic       calib_wr;
		logic       calib_sel;
		word_t      calib_src;
		logic       clk_run;
		logic       clk_lvl;
		half_cnt_t  half_cnt;
		bit_cnt_t   fall_cnt;
		logic       link_rst;
	} sys_state_t;

	typedef struct packed {
		word_t      sr;
		bit_cnt_t   cnt;
		word_t      word;
		logic       rs;
		logic       tgl;
	} wr_state_t;

	typedef struct packed {
		bit_cnt_t   cnt;
		logic       tgl;
	} rd_state_t;

	sys_state_t sys_reg;
	sys_state_t sys_next;
	wr_state_t  wr_reg;
	wr_state_t  wr_next;
	rd_state_t  rd_reg;
	rd_state_t  rd_next;
	logic       out_read;
	logic       mode_self;
	bit_cnt_t   rd_last;
	word_t      rd_src;
	logic       link_rst;

	assign mode_self = sys_reg.mode_sync[1];
	assign link_rst  = sys_reg.link_rst;

	// system side: strap, result capture, ready flag, register loads, own clock
	always_comb begin
		sys_next = sys_reg;
		sys_next.mode_sync   = {sys_reg.mode_sync[0], mode_self_i};
		sys_next.tfs_sync    = {sys_reg.tfs_sync[1:0], link.transmit_frame_sync_n};
		sys_next.rfs_sync    = {sys_reg.rfs_sync[0], link.read_frame_sync_n};
		sys_next.rs_sync     = {sys_reg.rs_sync[0], link.register_select};
		sys_next.wr_tgl_sync = {sys_reg.wr_tgl_sync[1:0], wr_reg.tgl};
		sys_next.rd_tgl_sync = {sys_reg.rd_tgl_sync[1:0], rd_reg.tgl};
		sys_next.ctrl_wr     = 1'b0;
		sys_next.calib_wr    = 1'b0;
		sys_next.link_rst    = 1'b0;
		sys_next.calib_sel   = calib_sel_i;
		// calibration source only refreshed while the read strobe is high, which includes the pause of a split read
		if (sys_reg.rfs_sync[1]) begin
			sys_next.calib_src = calib_rd_i;
		end
		// an output read counts as busy from strobe low until its last bit
		if (!sys_reg.busy && !sys_reg.rfs_sync[1] && sys_reg.rs_sync[1] && !sys_reg.calib_sel
			&& !sys_reg.data_ready_n_n) begin
			sys_next.busy = 1'b1;
		end
		if (sys_reg.rd_tgl_sync[2] != sys_reg.rd_tgl_sync[1] && sys_reg.busy) begin
			sys_next.busy   = 1'b0;
			sys_next.data_ready_n_n = 1'b1; // [R10] [R17] [R20]
		end
		// a new word overwrites an unread one but never one being shifted out
		if (out_valid_i && !sys_next.busy) begin
			sys_next.out_hold  = out_word_i; // [R11]
			sys_next.out_len24 = out_len24_i;
			sys_next.data_ready_n_n    = 1'b0; // [R10] [R11]
		end // [R12]
		// finished write: the link word is stable until the next 24 link edges
		if (sys_reg.wr_tgl_sync[2] != sys_reg.wr_tgl_sync[1]) begin
			if (!wr_reg.rs) begin
				sys_next.ctrl    = wr_reg.word; // [R4] [R3]
				sys_next.ctrl_wr = 1'b1;
			end else begin
				sys_next.calib    = wr_reg.word; // [R3]
				sys_next.calib_wr = 1'b1;
			end
		end // [R1]
		// own clock: starts on write strobe fall, stops low after the 24th fall
		if (!sys_reg.clk_run) begin
			if (mode_self && sys_reg.tfs_sync[2] && !sys_reg.tfs_sync[1]) begin
				sys_next.clk_run  = 1'b1; // [R5] [R8]
				sys_next.half_cnt = '0;
				sys_next.fall_cnt = '0;
				sys_next.clk_lvl  = 1'b0;
			end
		end else if (sys_reg.half_cnt == HALF_LAST) begin
			sys_next.half_cnt = '0;
			sys_next.clk_lvl  = !sys_reg.clk_lvl;
			if (sys_reg.clk_lvl) begin
				sys_next.fall_cnt = sys_reg.fall_cnt + 5'h01;
				if (sys_reg.fall_cnt == LAST_LONG) begin
					sys_next.clk_run = 1'b0; // [R6]
				end
			end
		end else begin
			sys_next.half_cnt = sys_reg.half_cnt + 8'h01;
		end
		if (srst_i) begin
			sys_next           = '0;
			sys_next.data_ready_n_n    = 1'b1;
			sys_next.ctrl      = CTRL_RESET;
			sys_next.out_hold  = WORD_RESET;
			sys_next.calib     = WORD_RESET;
			sys_next.tfs_sync  = 3'h7;
			sys_next.rfs_sync  = 2'h3;
			sys_next.link_rst  = 1'b1; // keeps the link-side shifters clear
		end
	end

	always_ff @(posedge clk_sys_i) begin
		sys_reg <= sys_next;
	end

	// write shifter: captures on rising link clock while the write strobe is low
	always_comb begin
		wr_next = wr_reg;
		if (!link.transmit_frame_sync_n) begin
			wr_next.sr = {wr_reg.sr[WORD_BITS-2:0], link.serial_data_line}; // [R21] [R5]
			// count is kept while the strobe is high so a split word resumes
			if (wr_reg.cnt == LAST_LONG) begin
				wr_next.cnt  = '0;
				wr_next.word = {wr_reg.sr[WORD_BITS-2:0], link.serial_data_line};
				wr_next.rs   = link.register_select; // [R3]
				wr_next.tgl  = !wr_reg.tgl;
			end else begin
				wr_next.cnt = wr_reg.cnt + 5'h01; // [R22] [R23]
			end
		end
	end

	// link clock is the resolved pin, driven by the host or by this end;
	// the clear is asynchronous since the link clock stands still during reset
	always_ff @(posedge link.sclk or posedge link_rst) begin
		if (link_rst) begin
			wr_reg <= '0;
		end else begin
			wr_reg <= wr_next;
		end
	end

	// read source: select low gives control, high gives output or calibration
	assign out_read = link.register_select && !sys_reg.calib_sel;
	always_comb begin
		if (!link.register_select) begin
			rd_src  = sys_reg.ctrl; // [R9]
			rd_last = LAST_LONG;
		end else if (sys_reg.calib_sel) begin
			rd_src  = sys_reg.calib_src; // [R9]
			rd_last = LAST_LONG;
		end else begin
			rd_src  = sys_reg.out_hold;
			rd_last = sys_reg.out_len24 ? LAST_LONG : LAST_SHORT;
		end
	end

	// read shifter: advances on falling link clock while the read strobe is low
	always_comb begin
		rd_next = rd_reg;
		// a refused output read moves nothing, so the count stays aligned
		if (!link.read_frame_sync_n && (!out_read || !sys_reg.data_ready_n_n)) begin // [R14]
			if (rd_reg.cnt == rd_last) begin
				rd_next.cnt = '0; // [R17]
				rd_next.tgl = !rd_reg.tgl;
			end else begin
				rd_next.cnt = rd_reg.cnt + 5'h01; // [R16] [R23]
			end
		end
	end

	always_ff @(negedge link.sclk or posedge link_rst) begin
		if (link_rst) begin
			rd_reg <= '0;
		end else begin
			rd_reg <= rd_next;
		end
	end

	// pins: data only while the read strobe is low, gated by ready on output reads
	assign link.serial_data_line_dev    = rd_src[5'(LAST_LONG - rd_reg.cnt)]; // [R16]
	assign link.serial_data_line_dev_oe = !link.read_frame_sync_n && (!out_read || !sys_reg.data_ready_n_n); // [R14] [R19] [R13]
	assign link.sclk_dev     = sys_reg.clk_lvl;
	assign link.sclk_dev_oe  = sys_reg.clk_run && mode_self; // [R7] [R8]
	assign link.data_ready_n = sys_reg.data_ready_n_n;
	assign ctrl_o            = sys_reg.ctrl;
	assign ctrl_wr_o         = sys_reg.ctrl_wr;
	assign calib_o           = sys_reg.calib;
	assign calib_wr_o        = sys_reg.calib_wr;
endmodule : converter_serial_port

// *** verilog/host_serial_port.sv ***
// host end of the serial link: runs frames on command, makes the clock in external mode
`timescale 1ns/1ps
module host_serial_port (
	// system clock and reset
	input  wire logic                      clk_sys_i,
	input  wire logic                      srst_i,
	// serial link
	serial_link_if.host                    link,
	// strap shared with the converter
	input  wire logic                      mode_self_i,
	// command port
	input  wire logic                      cmd_valid_i,
	output logic                           cmd_ready_o,
	input  wire logic                      cmd_write_i,
	input  wire logic                      cmd_sel_i,
	input  wire logic                      cmd_len24_i,
	input  wire logic                      cmd_split_i,
	input  wire serial_port_pkg::word_t    cmd_data_i,
	// answer port
	output logic                           rsp_valid_o,
	output serial_port_pkg::word_t         rsp_data_o,
	output logic                           data_ready_o
);
	import serial_port_pkg::*;

	typedef enum logic [5:0] {
		H_IDLE = 6'b000001,
		H_LOW  = 6'b000010,
		H_HIGH = 6'b000100,
		H_GAP  = 6'b001000,
		H_SELF = 6'b010000,
		H_END  = 6'b100000
	} host_fsm_t;

	typedef struct packed {
		host_fsm_t  st;
		half_cnt_t  half_cnt;
		bit_cnt_t   bit_cnt;
		bit_cnt_t   last;
		word_t      sr;
		logic       write;
		logic       sel;
		logic       split;
		logic       split_done;
		logic       sclk;
		logic       rfs_n;
		logic       tfs_n;
		logic       oe;
		logic [1:0] serial_data_line_sync;
		logic [2:0] sclk_sync;
		logic [1:0] data_ready_n_sync;
		logic [1:0] mode_sync;
		logic       rsp_valid;
		word_t      rsp;
	} host_state_t;

	host_state_t s_reg;
	host_state_t s_next;
	logic        half_done;

	assign half_done = s_reg.half_cnt == HALF_LAST;

	// frame sequencer: low half, high half per bit; clock idles low between frames
	always_comb begin
		s_next = s_reg;
		s_next.serial_data_line_sync = {s_reg.serial_data_line_sync[0], link.serial_data_line};
		s_next.sclk_sync  = {s_reg.sclk_sync[1:0], link.sclk};
		s_next.data_ready_n_sync  = {s_reg.data_ready_n_sync[0], link.data_ready_n};
		s_next.mode_sync  = {s_reg.mode_sync[0], mode_self_i};
		s_next.rsp_valid  = 1'b0;
		s_next.half_cnt   = half_done ? '0 : s_reg.half_cnt + 8'h01;
		unique case (s_reg.st)
			H_IDLE: begin
				s_next.half_cnt = '0;
				if (cmd_valid_i) begin
					s_next.write      = cmd_write_i;
					s_next.sel        = cmd_sel_i; // [R3] [R9]
					s_next.split      = cmd_split_i && !s_reg.mode_sync[1];
					s_next.split_done = 1'b0;
					s_next.sr         = cmd_data_i;
					s_next.bit_cnt    = '0;
					// writes and control reads are always 24 bits; select-high reads follow cmd_len24_i
					s_next.last  = (cmd_write_i || !cmd_sel_i || cmd_len24_i) ? LAST_LONG : LAST_SHORT; // [R2] [R15]
					s_next.oe    = cmd_write_i;
					s_next.tfs_n = !cmd_write_i;
					s_next.rfs_n = cmd_write_i;
					s_next.st    = (cmd_write_i && s_reg.mode_sync[1]) ? H_SELF : H_LOW;
				end
			end
			H_LOW: if (half_done) begin
				if (!s_reg.write) begin
					s_next.sr = {s_reg.sr[WORD_BITS-2:0], s_reg.serial_data_line_sync[1]};
				end
				s_next.sclk = 1'b1; // [R21]
				s_next.st   = H_HIGH;
			end
			H_HIGH: if (half_done) begin
				s_next.sclk    = 1'b0;
				s_next.bit_cnt = s_reg.bit_cnt + 5'h01;
				if (s_reg.write) begin
					s_next.sr = {s_reg.sr[WORD_BITS-2:0], 1'b0};
				end
				if (s_reg.bit_cnt == s_reg.last) begin
					s_next.st = H_END;
				end else if (s_reg.split && !s_reg.split_done && s_reg.bit_cnt == SPLIT_BIT) begin
					s_next.split_done = 1'b1;
					s_next.st         = H_GAP;
				end else begin
					s_next.st = H_LOW;
				end
			end
			H_GAP: begin
				// strobes rise one cycle after the falling edge, never with it
				if (s_reg.half_cnt == '0) begin
					s_next.rfs_n = 1'b1; // [R19] [R22]
					s_next.tfs_n = 1'b1;
				end
				if (half_done) begin
					s_next.rfs_n = s_reg.write;
					s_next.tfs_n = !s_reg.write;
					s_next.st    = H_LOW;
				end
			end
			H_SELF: begin
				// converter owns the clock: present next bit after each falling edge
				s_next.half_cnt = '0;
				if (s_reg.sclk_sync[2] && !s_reg.sclk_sync[1]) begin
					s_next.sr      = {s_reg.sr[WORD_BITS-2:0], 1'b0};
					s_next.bit_cnt = s_reg.bit_cnt + 5'h01;
					if (s_reg.bit_cnt == LAST_LONG) begin
						s_next.st = H_END;
					end
				end
			end
			H_END: if (half_done) begin
				s_next.rfs_n     = 1'b1;
				s_next.tfs_n     = 1'b1;
				s_next.oe        = 1'b0;
				s_next.rsp_valid = !s_reg.write;
				s_next.rsp       = s_reg.write ? s_reg.rsp : s_reg.sr;
				s_next.st        = H_IDLE;
			end
		endcase
		if (srst_i) begin
			s_next       = '0;
			s_next.st    = H_IDLE;
			s_next.rfs_n = 1'b1;
			s_next.tfs_n = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		s_reg <= s_next;
	end

	// clock is driven whenever this end owns it and rests low between frames
	assign link.sclk_host             = s_reg.sclk; // [R18]
	assign link.sclk_host_oe          = !s_reg.mode_sync[1];
	assign link.serial_data_line_host            = s_reg.sr[WORD_BITS-1];
	assign link.serial_data_line_host_oe         = s_reg.oe;
	assign link.read_frame_sync_n     = s_reg.rfs_n;
	assign link.transmit_frame_sync_n = s_reg.tfs_n;
	assign link.register_select       = s_reg.sel;
	assign cmd_ready_o                = s_reg.st == H_IDLE;
	assign rsp_valid_o                = s_reg.rsp_valid;
	assign rsp_data_o                 = s_reg.rsp;
	assign data_ready_o               = !s_reg.data_ready_n_sync[1];
endmodule : host_serial_port

// *** bench/serial_link_properties.sv ***
// protocol assertions watching the serial link between host and converter
`timescale 1ns/1ps
module serial_link_properties (
	// system clock and reset
	input wire logic clk_sys_i,
	input wire logic srst_i,
	// link signals
	input wire logic sclk,
	input wire logic sclk_dev_oe,
	input wire logic sclk_host_oe,
	input wire logic serial_data_line_dev_oe,
	input wire logic read_frame_sync_n,
	input wire logic transmit_frame_sync_n,
	input wire logic register_select,
	input wire logic data_ready_n
);
	logic [4:0] dev_falls_reg;
	logic [4:0] rd_falls_reg;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);
	// falling edges of the converter's own clock within one write frame
	always_ff @(posedge clk_sys_i) begin
		if (srst_i || transmit_frame_sync_n)
			dev_falls_reg <= 5'h00;
		else if ($fell(sclk) && $past(sclk_dev_oe))
			dev_falls_reg <= dev_falls_reg + 5'h01;
	end
	// read falling edges, kept across strobe pauses, cleared when a whole word is done or while the write strobe is low
	always_ff @(posedge clk_sys_i) begin
		if (srst_i || !transmit_frame_sync_n || $rose(data_ready_n))
			rd_falls_reg <= 5'h00;
		else if ($fell(read_frame_sync_n) && rd_falls_reg == 5'h18)
			rd_falls_reg <= 5'h00;
		else if ($fell(sclk) && !$past(read_frame_sync_n))
			rd_falls_reg <= rd_falls_reg + 5'h01;
	end
	write_keeps_ready_a: assert property (
		!transmit_frame_sync_n && read_frame_sync_n |-> !$rose(data_ready_n)) else $error("ready rose in a write");
	select_held_a: assert property (
		(!read_frame_sync_n || !transmit_frame_sync_n) && (!$past(read_frame_sync_n) || !$past(transmit_frame_sync_n))
		|-> $stable(register_select)) else $error("select moved in a frame");
	self_clk_start_a: assert property (
		$fell(transmit_frame_sync_n) && !sclk_host_oe |-> ##[1:6] sclk_dev_oe) else $error("own clock not started");
	self_clk_stop_a: assert property (
		$fell(sclk) && $past(sclk_dev_oe) && dev_falls_reg == 5'h17 |-> ##[0:6] !sclk_dev_oe)
		else $error("own clock not stopped");
	self_falls_max_a: assert property (dev_falls_reg <= 5'h18) else $error("too many clock pulses");
	single_clk_driver_a: assert property (sclk_host_oe |-> !sclk_dev_oe) else $error("two clock drivers");
	paused_read_quiet_a: assert property (
		read_frame_sync_n && $past(read_frame_sync_n) |-> !serial_data_line_dev_oe) else $error("data driven off frame");
	strobe_rise_low_a: assert property (
		$rose(read_frame_sync_n) || $rose(transmit_frame_sync_n) |-> !sclk && !$past(sclk))
		else $error("strobe rose with clock high");
	ready_after_word_a: assert property (
		$rose(data_ready_n) |-> !serial_data_line_dev_oe && (rd_falls_reg == 5'h10 || rd_falls_reg == 5'h18))
		else $error("ready rose mid word");
	idle_clock_low_a: assert property (
		read_frame_sync_n && transmit_frame_sync_n && $past(read_frame_sync_n) && $past(transmit_frame_sync_n)
		|-> !sclk) else $error("clock high while idle");
	write_no_drive_a: assert property (!transmit_frame_sync_n |-> !serial_data_line_dev_oe) else $error("data driven in write");
	cover property (!transmit_frame_sync_n && sclk_dev_oe);
	cover property ($rose(data_ready_n) && rd_falls_reg == 5'h10);
	cover property ($rose(read_frame_sync_n) && !data_ready_n && rd_falls_reg < 5'h10);
endmodule : serial_link_properties

// *** bench/tb.sv ***
// self-checking bench: host and converter ends joined over the serial link
`timescale 1ns/1ps
module tb;
	import serial_port_pkg::*;
	localparam int LIMIT = 60000;
	logic  clk_sys_i = 1'b0;
	logic  srst_i    = 1'b1;
	logic  mode_self = 1'b0;
	logic  calib_sel = 1'b0;
	word_t out_word  = 24'h000000;
	logic  out_valid = 1'b0;
	logic  out_len24 = 1'b1;
	word_t calib_rd  = 24'h3C5A96;
	logic  cmd_valid = 1'b0;
	logic  cmd_write = 1'b0;
	logic  cmd_sel   = 1'b0;
	logic  cmd_len24 = 1'b1;
	logic  cmd_split = 1'b0;
	word_t cmd_data  = 24'h000000;
	logic  cmd_ready, rsp_valid, data_ready, ctrl_wr, calib_wr;
	word_t rsp_data, ctrl, calib, last_rsp;
	word_t wr_shift  = 24'h000000;
	word_t rd_shift  = 24'h000000;
	int    err_count = 0;
	int    n_compared = 0;
	int    cycles = 0;
	int    n_ctrl_wr = 0;
	serial_link_if link ();
	converter_serial_port u_converter_serial_port (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .link(link.device),
		.mode_self_i(mode_self), .calib_sel_i(calib_sel), .out_word_i(out_word), .out_valid_i(out_valid),
		.out_len24_i(out_len24), .calib_rd_i(calib_rd), .ctrl_o(ctrl), .ctrl_wr_o(ctrl_wr), .calib_o(calib),
		.calib_wr_o(calib_wr));
	host_serial_port u_host_serial_port (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .link(link.host),
		.mode_self_i(mode_self), .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_write_i(cmd_write),
		.cmd_sel_i(cmd_sel), .cmd_len24_i(cmd_len24), .cmd_split_i(cmd_split), .cmd_data_i(cmd_data),
		.rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data), .data_ready_o(data_ready));
	serial_link_properties u_serial_link_properties (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .sclk(link.sclk),
		.sclk_dev_oe(link.sclk_dev_oe), .sclk_host_oe(link.sclk_host_oe), .serial_data_line_dev_oe(link.serial_data_line_dev_oe),
		.read_frame_sync_n(link.read_frame_sync_n), .transmit_frame_sync_n(link.transmit_frame_sync_n),
		.register_select(link.register_select), .data_ready_n(link.data_ready_n));
	initial begin
		forever #2.5 clk_sys_i = ~clk_sys_i;
	end
	// hang guard and control write pulse count
	always @(posedge clk_sys_i) begin
		cycles++;
		if (ctrl_wr === 1'b1)
			n_ctrl_wr++;
		if (cycles == LIMIT) begin
			err_count++;
			conclude();
		end
	end
	// wire monitor: what crosses on each rising link clock edge, MSB first
	always @(posedge link.sclk) begin
		if (link.transmit_frame_sync_n === 1'b0)
			wr_shift <= {wr_shift[22:0], link.serial_data_line};
		if (link.read_frame_sync_n === 1'b0)
			rd_shift <= {rd_shift[22:0], link.serial_data_line};
	end
	task automatic check(input string what, input word_t seen, input word_t exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// one host frame; writes end when the host is idle again, reads on the answer pulse
	task automatic run(input logic wr, input logic sel, input logic len24, input logic split, input word_t data);
		int n;
		n = 0;
		@(negedge clk_sys_i);
		while (cmd_ready !== 1'b1 && n < 4000) begin
			@(negedge clk_sys_i);
			n++;
		end
		@(posedge clk_sys_i);
		cmd_valid <= 1'b1;
		cmd_write <= wr;
		cmd_sel   <= sel;
		cmd_len24 <= len24;
		cmd_split <= split;
		cmd_data  <= data;
		@(posedge clk_sys_i);
		cmd_valid <= 1'b0;
		@(negedge clk_sys_i);
		while ((wr ? cmd_ready !== 1'b1 : rsp_valid !== 1'b1) && n < 4000) begin
			@(negedge clk_sys_i);
			n++;
		end
		if (n >= 4000)
			check("transfer end", 24'h000000, 24'h000001);
		last_rsp = rsp_data;
		repeat (12) @(posedge clk_sys_i);
	endtask : run
	// a new conversion result arrives at the converter
	task automatic new_word(input word_t w, input logic l24);
		@(posedge clk_sys_i);
		out_word  <= w;
		out_len24 <= l24;
		out_valid <= 1'b1;
		@(posedge clk_sys_i);
		out_valid <= 1'b0;
		repeat (8) @(posedge clk_sys_i);
	endtask : new_word
	task automatic conclude();
		if (err_count == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : conclude
	initial begin
		repeat (2) @(posedge clk_sys_i);
		srst_i <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
		// external clock: control and calibration writes, then calibration data and control reads
		run(1'b1, 1'b0, 1'b1, 1'b0, 24'hA5C3F1);
		check("ctrl", ctrl, 24'hA5C3F1);
		check("write bits", wr_shift, 24'hA5C3F1);
		check("ready line", {23'h000000, link.data_ready_n}, 24'h000001);
		calib_sel <= 1'b1;
		run(1'b1, 1'b1, 1'b1, 1'b0, 24'h5E0A7C);
		check("calib", calib, 24'h5E0A7C);
		check("ctrl kept", ctrl, 24'hA5C3F1);
		run(1'b0, 1'b1, 1'b1, 1'b0, 24'h000000);
		check("calib read", last_rsp, 24'h3C5A96);
		run(1'b0, 1'b0, 1'b1, 1'b0, 24'h000000);
		check("ctrl read", last_rsp, 24'hA5C3F1);
		check("read bits", rd_shift, 24'hA5C3F1);
		// output register with nothing ready gives an undriven line
		calib_sel <= 1'b0;
		run(1'b0, 1'b1, 1'b1, 1'b0, 24'h000000);
		check("idle read", last_rsp, 24'hFFFFFF);
		new_word(24'h123456, 1'b1);
		new_word(24'h9ABCDE, 1'b1);
		check("ready low", {23'h000000, link.data_ready_n}, 24'h000000);
		check("ready flag", {23'h000000, data_ready}, 24'h000001);
		run(1'b1, 1'b0, 1'b1, 1'b0, 24'h0F1E2D);
		check("ready kept", {23'h000000, link.data_ready_n}, 24'h000000);
		run(1'b0, 1'b0, 1'b1, 1'b0, 24'h000000);
		check("ctrl read2", last_rsp, 24'h0F1E2D);
		check("ready kept2", {23'h000000, link.data_ready_n}, 24'h000000);
		run(1'b0, 1'b1, 1'b1, 1'b0, 24'h000000);
		check("latest word", last_rsp, 24'h9ABCDE);
		check("ready high", {23'h000000, link.data_ready_n}, 24'h000001);
		// short word, then split read and split write
		new_word(24'hBEEF00, 1'b0);
		run(1'b0, 1'b1, 1'b0, 1'b0, 24'h000000);
		check("short word", {8'h00, last_rsp[15:0]}, 24'h00BEEF);
		check("short done", {23'h000000, link.data_ready_n}, 24'h000001);
		new_word(24'hC0FFEE, 1'b1);
		run(1'b0, 1'b1, 1'b1, 1'b1, 24'h000000);
		check("split read", last_rsp, 24'hC0FFEE);
		check("split done", {23'h000000, link.data_ready_n}, 24'h000001);
		run(1'b1, 1'b0, 1'b1, 1'b1, 24'h6D2B99);
		check("split write", ctrl, 24'h6D2B99);
		// a word landing mid-read is lost
		new_word(24'h2468AC, 1'b1);
		fork
			run(1'b0, 1'b1, 1'b1, 1'b0, 24'h000000);
			begin
				repeat (300) @(posedge clk_sys_i);
				new_word(24'h777777, 1'b1);
			end
		join
		check("busy word", last_rsp, 24'h2468AC);
		check("busy drop", {23'h000000, link.data_ready_n}, 24'h000001);
		// converter makes the clock for writes
		mode_self <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		run(1'b1, 1'b0, 1'b1, 1'b0, 24'h13579B);
		check("self write", ctrl, 24'h13579B);
		check("self bits", wr_shift, 24'h13579B);
		check("ctrl pulses", 24'(n_ctrl_wr), 24'h000004);
		conclude();
	end
endmodule : tb
